// ---- include/ret_rot_pkg.sv ----
package ret_rot_pkg;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W = 15;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic CARRY_RESET = 1'b0;
	localparam logic [14:0] PC_RESET = 15'h0000;
	localparam int RET_CYCLES = 2;
	localparam int ROT_CYCLES = 1;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_RETURN = 3'h1,
		OP_RETURN_WITH_LITERAL = 3'h2,
		OP_ROTATE_LEFT_CARRY = 3'h3,
		OP_ROTATE_RIGHT_CARRY = 3'h4
	} op_t;

	typedef struct packed {
		op_t op;
		logic dest;
		logic [6:0] faddr;
		logic [7:0] literal;
	} instr_t;

	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} fwrite_t;
endpackage

// ---- rtl/rotate_carry.sv ----
`timescale 1ns/1ps
module rotate_carry
	import ret_rot_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input wire logic [WIDTH-1:0] i_data, // Source value
	input wire logic i_carry, // Carry before the rotate
	input wire logic i_right, // 1 rotates right, 0 left
	output logic [WIDTH-1:0] o_data, // Rotated value
	output logic o_carry // Carry after the rotate
);
	always_comb begin
		if (i_right) begin
			o_data = {i_carry, i_data[WIDTH-1:1]};
			o_carry = i_data[0];
		end else begin
			o_data = {i_data[WIDTH-2:0], i_carry};
			o_carry = i_data[WIDTH-1];
		end
	end
endmodule

// ---- rtl/return_and_rotate_exec.sv ----
`timescale 1ns/1ps
// Functional notes
// - A plain return pops the stack and loads its top into the program counter over two cycles, flags untouched.
// - Return-with-literal writes its 8-bit operand, any value 0 to 255, into the accumulator.
// - Return-with-literal also loads the popped return address into the program counter, one word, two cycles, flags untouched.
// - Rotate-left shifts the file value left through carry, old carry into bit 0, old bit 7 into carry, in one cycle.
// - Rotate-left with select 0 writes the accumulator only, with select 1 writes back to the file register 0 to 127.
// - Rotate-right shifts right through carry, old carry into bit 7, old bit 0 into carry, carry the only flag touched.
// - Rotate-right with select 0 writes the accumulator, with select 1 writes the addressed file register.
module return_and_rotate_exec
	import ret_rot_pkg::*;
(
	input wire logic i_clk, // Core clock
	input wire logic i_resetn, // Async reset, active low
	input wire logic i_valid, // Instruction presented this cycle
	input wire instr_t i_instr, // Decoded instruction
	input wire logic [DATA_W-1:0] i_file_data, // File register read value
	input wire logic [PC_W-1:0] i_stack_top, // Current top of return stack
	output logic o_ready, // Can take an instruction
	output logic [FADDR_W-1:0] o_file_raddr, // File read address
	output fwrite_t o_file_wr, // File write-back
	output logic o_stack_pop, // One-cycle stack pop
	output logic o_pc_load, // PC load pulse
	output logic [PC_W-1:0] o_pc, // New PC value
	output logic [DATA_W-1:0] o_acc, // Accumulator
	output logic o_carry // Carry flag
);
	////////////////////////////////////////////////////////////////
	logic rst_meta_reg, rst_sync_reg;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire logic rst_n = rst_sync_reg;

	////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		ST_EXEC = 2'b01,
		ST_RET2 = 2'b10
	} state_t;

	state_t state_reg, state_next;
	logic [DATA_W-1:0] acc_reg, acc_next;
	logic carry_reg, carry_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic pc_load_reg, pc_load_next;
	logic pop_reg, pop_next;
	fwrite_t wr_reg, wr_next;
	logic [DATA_W-1:0] rot_data;
	logic rot_carry;
	logic rot_right;

	////////////////////////////////////////////////////////////////
	// One datapath serves both rotate directions
	rotate_carry #(
		.WIDTH(DATA_W)
	) u_rot (
		.i_data(i_file_data),
		.i_carry(carry_reg),
		.i_right(rot_right),
		.o_data(rot_data),
		.o_carry(rot_carry)
	);

	// Second return cycle is a flush slot, so the core holds off
	assign o_ready = (state_reg == ST_EXEC);
	assign o_file_raddr = i_instr.faddr;

	////////////////////////////////////////////////////////////////
	// Decode of the instruction taken this cycle
	logic take;
	logic is_ret;
	logic is_lit;
	logic is_rot;
	logic to_file;

	always_comb begin
		take = i_valid && o_ready;
		is_ret = 1'b0;
		is_lit = 1'b0;
		is_rot = 1'b0;
		to_file = (i_instr.dest == DEST_FILE);
		rot_right = (i_instr.op == OP_ROTATE_RIGHT_CARRY);
		// A refused slot decodes to nothing
		if (take) begin
			case (i_instr.op)
				OP_RETURN: begin
					is_ret = 1'b1;
				end
				OP_RETURN_WITH_LITERAL: begin
					is_lit = 1'b1;
				end
				OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: begin
					is_rot = 1'b1;
				end
				default: begin
					// Empty or unknown codes fall through as a no-op
					is_rot = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_EXEC: begin
				// Rotates stay here, so one issues every cycle
				if (is_ret || is_lit) begin
					state_next = ST_RET2;
				end
			end
			ST_RET2: begin
				// Flush slot of a return, nothing issues
				state_next = ST_EXEC;
			end
			default: begin
				state_next = ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_EXEC;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Accumulator and carry
	always_comb begin
		acc_next = acc_reg;
		carry_next = carry_reg;
		if (is_lit) begin
			acc_next = i_instr.literal;
		end
		if (is_rot) begin
			// Returns never reach here, so they leave the carry alone
			carry_next = rot_carry;
			if (!to_file) begin
				acc_next = rot_data;
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= ACC_RESET;
			carry_reg <= CARRY_RESET;
		end else begin
			acc_reg <= acc_next;
			carry_reg <= carry_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Program counter and stack pop
	always_comb begin
		pc_next = pc_reg;
		pc_load_next = 1'b0;
		pop_next = 1'b0;
		// Load and pop pulse for one cycle only
		if (is_ret || is_lit) begin
			pc_next = i_stack_top;
			pc_load_next = 1'b1;
			pop_next = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= PC_RESET;
			pc_load_reg <= 1'b0;
			pop_reg <= 1'b0;
		end else begin
			pc_reg <= pc_next;
			pc_load_reg <= pc_load_next;
			pop_reg <= pop_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// File write-back
	always_comb begin
		wr_next.en = 1'b0;
		wr_next.addr = '0;
		wr_next.data = '0;
		if (is_rot && to_file) begin
			// Select 0 leaves the source register untouched
			wr_next.en = 1'b1;
			wr_next.addr = i_instr.faddr;
			wr_next.data = rot_data;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg <= '0;
		end else begin
			wr_reg <= wr_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs come straight from the registers above
	assign o_acc = acc_reg;
	assign o_carry = carry_reg;
	assign o_pc = pc_reg;
	assign o_pc_load = pc_load_reg;
	assign o_stack_pop = pop_reg;
	assign o_file_wr = wr_reg;
endmodule

// ---- tb/ret_rot_checker.sv ----
`timescale 1ns/1ps
module ret_rot_checker
	import ret_rot_pkg::*;
(
	input wire logic i_clk, // Core clock
	input wire logic i_resetn, // Raw reset, active low
	input wire logic i_valid, // Instruction presented
	input wire instr_t i_instr, // Decoded instruction
	input wire logic [7:0] i_file_data, // File read value
	input wire logic [14:0] i_stack_top, // Return address
	input wire logic o_ready, // Issue slot open
	input wire fwrite_t o_file_wr, // File write-back
	input wire logic o_stack_pop, // Pop pulse
	input wire logic o_pc_load, // PC load pulse
	input wire logic [14:0] o_pc, // New PC
	input wire logic [7:0] o_acc, // Accumulator
	input wire logic o_carry // Carry flag
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	wire tk = i_valid && o_ready;
	wire ret = tk && i_instr.op == OP_RETURN;
	wire lit = tk && i_instr.op == OP_RETURN_WITH_LITERAL;
	wire rl = tk && i_instr.op == OP_ROTATE_LEFT_CARRY;
	wire rr = tk && i_instr.op == OP_ROTATE_RIGHT_CARRY;
	////////////////////////////////////////
	ret_pop_a: assert property (ret |=> o_stack_pop && o_pc == $past(i_stack_top) && $stable(o_carry))
		else $error("bad return");
	ret_slot_a: assert property (lit |=> !o_ready ##1 o_ready && !o_pc_load)
		else $error("bad return slot");
	ret_ready_a: assert property (ret |=> !o_ready ##1 o_ready && !o_stack_pop)
		else $error("bad plain return slot");
	lit_acc_a: assert property (lit |=> o_acc == $past(i_instr.literal))
		else $error("bad literal");
	lit_pc_a: assert property (lit |=> o_pc_load && o_pc == $past(i_stack_top) && $stable(o_carry))
		else $error("bad literal pc");
	rl_carry_a: assert property (rl |=> o_carry == $past(i_file_data[7]))
		else $error("bad left carry");
	rl_acc_a: assert property (rl && !i_instr.dest |=> o_acc == {$past(i_file_data[6:0]), $past(o_carry)}
		&& !o_file_wr.en) else $error("bad left dest");
	rl_file_a: assert property (rl && i_instr.dest |=> $stable(o_acc) && o_file_wr == {1'b1,
		$past(i_instr.faddr), $past(i_file_data[6:0]), $past(o_carry)}) else $error("bad left wb");
	rr_acc_a: assert property (rr && !i_instr.dest |=> !o_file_wr.en
		&& o_acc == {$past(o_carry), $past(i_file_data[7:1])}) else $error("bad right dest");
	rr_carry_a: assert property (rr |=> o_carry == $past(i_file_data[0]) && o_ready)
		else $error("bad right carry");
	rr_file_a: assert property (rr && i_instr.dest |=> o_file_wr == {1'b1, $past(i_instr.faddr),
		$past(o_carry), $past(i_file_data[7:1])}) else $error("bad right wb");
endmodule
bind return_and_rotate_exec ret_rot_checker chk_i(
	.i_clk(i_clk),
	.i_resetn(i_resetn),
	.i_valid(i_valid),
	.i_instr(i_instr),
	.i_file_data(i_file_data),
	.i_stack_top(i_stack_top),
	.o_ready(o_ready),
	.o_file_wr(o_file_wr),
	.o_stack_pop(o_stack_pop),
	.o_pc_load(o_pc_load),
	.o_pc(o_pc),
	.o_acc(o_acc),
	.o_carry(o_carry)
);

// ---- tb/return_and_rotate_exec_bench.sv ----
`timescale 1ns/1ps
module return_and_rotate_exec_bench;
	import ret_rot_pkg::*;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_valid = 1'b0;
	instr_t i_instr = '0;
	logic [7:0] fd = 8'h00;
	logic [14:0] st = 15'h0000;
	logic o_ready, o_pl, o_sp, o_carry;
	fwrite_t o_fw;
	logic [6:0] o_ra;
	logic [14:0] o_pc, ep = 15'h0000;
	logic [7:0] o_acc, ea = 8'h00;
	logic ec = 1'b0;
	int error_cnt = 0, cmp_count = 0;
	return_and_rotate_exec uut(.i_clk(i_clk), .i_resetn(i_resetn), .i_valid(i_valid), .i_instr(i_instr),
		.i_file_data(fd), .i_stack_top(st), .o_ready(o_ready), .o_file_raddr(o_ra), .o_file_wr(o_fw),
		.o_stack_pop(o_sp), .o_pc_load(o_pl), .o_pc(o_pc), .o_acc(o_acc), .o_carry(o_carry));
	initial forever #10 i_clk = ~i_clk;
	////////////////////////////////////////
	task automatic chk(input logic [42:0] g, input logic [42:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Checks run 1 ns after the edge so the next request can go out back to back
	task automatic run(input op_t op, input logic d, input logic [7:0] v);
		logic [7:0] r;
		logic w;
		r = (op == OP_ROTATE_LEFT_CARRY) ? {v[6:0], ec} : {ec, v[7:1]};
		w = op > OP_RETURN_WITH_LITERAL;
		i_valid <= 1'b1;
		i_instr <= '{op: op, dest: d, faddr: v[6:0], literal: v};
		fd <= v;
		st <= {7'h2A, v};
		#1 chk({36'h0, o_ra}, {36'h0, v[6:0]});
		@(posedge i_clk);
		if (w) begin
			ec = (op == OP_ROTATE_LEFT_CARRY) ? v[7] : v[0];
			if (!d) ea = r;
		end else begin
			ep = {7'h2A, v};
			if (op == OP_RETURN_WITH_LITERAL) ea = v;
		end
		fork
			#1 chk({o_acc, o_carry, o_pl, o_sp, o_pc, o_ready, o_fw.en, o_fw.en ? o_fw[14:0] : 15'h0000},
				{ea, ec, !w, !w, ep, w, w && d, (w && d) ? {v[6:0], r} : 15'h0000});
		join_none
	endtask
	task automatic gap;
		i_valid <= 1'b0;
		@(posedge i_clk);
		// Judged here so every scenario ends with its checks done
		#1 chk({39'h0, o_ready, o_pl, o_sp, o_fw.en}, 43'h8);
		@(posedge i_clk);
	endtask
	task automatic t_ret;
		run(OP_RETURN, 1'b0, 8'hA5);
		gap();
	endtask
	task automatic t_lit;
		run(OP_RETURN_WITH_LITERAL, 1'b0, 8'h00);
		gap();
		run(OP_RETURN_WITH_LITERAL, 1'b0, 8'hFF);
		gap();
	endtask
	task automatic t_rot;
		run(OP_ROTATE_LEFT_CARRY, 1'b0, 8'hE6);
		run(OP_ROTATE_LEFT_CARRY, 1'b1, 8'h81);
		run(OP_ROTATE_RIGHT_CARRY, 1'b1, 8'h01);
		run(OP_ROTATE_RIGHT_CARRY, 1'b0, 8'h80);
		gap();
	endtask
	task automatic finish_test;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#40000;
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (3) @(posedge i_clk);
		t_ret();
		t_lit();
		t_rot();
		t_ret();
		@(posedge i_clk);
		#2;
		finish_test();
	end
endmodule
